// >>> timer8_chk.sv
// property checks on the timer's bus answers, prescaler taps and interrupt
`timescale 1ns/1ps
module timer8_chk (
	// clock, reset and bus
	input wire logic        sys_clk_i,
	input wire logic        rst_n_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [11:0] paddr_i,
	// timer outputs
	input wire logic [31:0] prdata_o,
	input wire logic        pslverr_o,
	input wire logic [3:0]  presc_tap_en_o,
	input wire logic        irq_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	wire       rd = psel_i && !penable_i && !pwrite_i;
	wire       ok = paddr_i inside {12'hcc, 12'hc8, 12'he0, 12'he4};
	wire [3:0] t  = presc_tap_en_o;
	a_tap8_period: assert property (t[0] |-> ##8 t[0]) else $error("tap8 period");
	a_tap8_quiet: assert property (t[0] |=> !t[0] [*7]) else $error("tap8 early");
	a_tap64_period: assert property (t[1] |-> ##64 t[1]) else $error("tap64 period");
	a_taps_nested: assert property (t[3] |-> t[2] && t[1] && t[0]) else $error("taps");
	a_ctrl_upper_zero: assert property (rd && paddr_i == 12'hcc |=> prdata_o[31:3] == 29'h0)
		else $error("ctrl upper bits");
	a_count_width: assert property (rd && paddr_i == 12'hc8 |=> prdata_o[31:8] == 24'h0)
		else $error("count width");
	a_irq_flag_mask: assert property (rd && irq_o && paddr_i[11:3] == 9'h1c |=> prdata_o[0])
		else $error("irq without flag and enable");
	a_err_unmapped: assert property (psel_i && penable_i |-> pslverr_o == !ok)
		else $error("slave error");
	cover property (irq_o);
	cover property (pslverr_o);
	cover property (t[3]);
endmodule : timer8_chk

// >>> timer8_defines.svh
// offsets, field positions, reset values and prescaler taps for the 8-bit timer
`ifndef TIMER8_DEFINES_SVH
`define TIMER8_DEFINES_SVH
`define T8_CTRL_IDX        8'h33
`define T8_COUNT_IDX       8'h32
`define T8_FLAG_IDX        8'h38
`define T8_MASK_IDX        8'h39
`define T8_CTRL_RESET      3'h0
`define T8_COUNT_RESET     8'h00
`define T8_PRESC_WIDTH     10
`define T8_PRESC_RESET     10'h000
`define T8_TAP8            2
`define T8_TAP64           5
`define T8_TAP256          7
`define T8_TAP1024         9
`define T8_OVF_BIT         0
`define T8_CTRL_WIDTH      3
`endif

// >>> timer8_pin_src.sv
// count pin source model with chosen level hold
`timescale 1ns/1ps
module timer8_pin_src (
	// clock and pin
	input  wire logic sys_clk_i,
	output logic      pin_o
);
	initial pin_o = 1'b0;
	task automatic pulse(input int n, input int hold);
		repeat (n)
		begin
			repeat (hold) @(posedge sys_clk_i);
			pin_o <= 1'b1;
			repeat (hold) @(posedge sys_clk_i);
			pin_o <= 1'b0;
		end
	endtask : pulse
endmodule : timer8_pin_src

// >>> timer8_pkg.sv
// types for the 8-bit timer
package timer8_pkg;
	typedef enum logic [2:0] {
		clk_src_stop,
		clk_src_core,
		clk_src_div8,
		clk_src_div64,
		clk_src_div256,
		clk_src_div1024,
		clk_src_pin_fall,
		clk_src_pin_rise
	} clk_sel_type;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  idx;
		logic [31:0] wdata;
	} bus_req_type;

	typedef struct packed {
		logic [9:0] taps;
	} presc_type;
endpackage : timer8_pkg

// >>> timer8_prescaler.sv
// free-running shared prescaler with divided-clock enable taps
`timescale 1ns/1ps
`include "timer8_defines.svh"
module timer8_prescaler
	import timer8_pkg::*;
(
	// clock and reset
	input  wire logic         sys_clk_i,
	input  wire logic         rst_n_i,
	// divided enables
	output presc_type         presc_o,
	output logic     [3:0]    tap_en_o
);
	logic [`T8_PRESC_WIDTH-1:0] cnt_q;
	logic [`T8_PRESC_WIDTH-1:0] cnt_d;

	// counts the core clock only
	assign cnt_d = cnt_q + 10'h001;

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			cnt_q <= `T8_PRESC_RESET;
		else
			cnt_q <= cnt_d;
	end

	assign presc_o.taps = cnt_q;
	// one-cycle pulse each time the low bits roll over
	assign tap_en_o[0] = &cnt_q[`T8_TAP8:0];
	assign tap_en_o[1] = &cnt_q[`T8_TAP64:0];
	assign tap_en_o[2] = &cnt_q[`T8_TAP256:0];
	assign tap_en_o[3] = &cnt_q[`T8_TAP1024:0];
endmodule : timer8_prescaler

// >>> timer8_with_shared_prescaler.sv
// 8-bit up timer/counter with shared prescaler, pin counting and apb registers
`timescale 1ns/1ps
`include "timer8_defines.svh"
module timer8_with_shared_prescaler
	import timer8_pkg::*;
(
	// clock and reset
	input  wire logic         sys_clk_i,
	input  wire logic         rst_n_i,
	// apb slave
	input  wire logic         psel_i,
	input  wire logic         penable_i,
	input  wire logic         pwrite_i,
	input  wire logic [11:0]  paddr_i,
	input  wire logic [31:0]  pwdata_i,
	input  wire logic [3:0]   pstrb_i,
	output logic      [31:0]  prdata_o,
	output logic              pready_o,
	output logic              pslverr_o,
	// count pin, as seen at the pad whatever its direction
	input  wire logic         timer0_count_pin_i,
	// prescaler taps offered to the other timer
	output logic      [3:0]   presc_tap_en_o,
	// interrupt
	output logic              irq_o
);
	bus_req_type  req;
	clk_sel_type  clk_sel;
	presc_type    presc;
	logic [3:0]   tap_en;
	logic [2:0]   ctrl_q;
	logic [7:0]   count_q;
	logic [7:0]   count_d;
	logic         ovf_q;
	logic         ovf_d;
	logic         ovf_en_q;
	logic         pin_meta_q;
	logic         pin_sync_q;
	logic         pin_prev_q;
	logic [31:0]  rdata_q;
	logic         pin_rise;
	logic         pin_fall;
	logic         tick;
	logic         wrap;
	logic         acc;
	logic         hit_ctrl;
	logic         hit_count;
	logic         hit_flag;
	logic         hit_mask;
	logic         hit_any;
	logic [31:0]  rdata_d;

	function automatic logic idx_hit(input logic [11:0] addr, input logic [7:0] idx);
		idx_hit = (addr[1:0] == 2'h0) && (addr[11:2] == {2'h0, idx});
	endfunction : idx_hit

	timer8_prescaler u_presc
	(
		.sys_clk_i (sys_clk_i),
		.rst_n_i   (rst_n_i),
		.presc_o   (presc),
		.tap_en_o  (tap_en)
	);

	assign presc_tap_en_o = tap_en;

	// apb decode
	assign acc         = psel_i && penable_i;
	assign req.wr      = acc && pwrite_i && pstrb_i[0];
	assign req.rd      = acc && !pwrite_i;
	assign req.idx     = paddr_i[9:2];
	assign req.wdata   = pwdata_i;
	assign hit_ctrl    = idx_hit(paddr_i, `T8_CTRL_IDX);
	assign hit_count   = idx_hit(paddr_i, `T8_COUNT_IDX);
	assign hit_flag    = idx_hit(paddr_i, `T8_FLAG_IDX);
	assign hit_mask    = idx_hit(paddr_i, `T8_MASK_IDX);
	assign hit_any     = hit_ctrl || hit_count || hit_flag || hit_mask;
	assign pready_o    = 1'b1;
	assign pslverr_o   = acc && !hit_any;

	// two-stage synchroniser, then edge detect on later stages
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			pin_meta_q <= 1'b0;
			pin_sync_q <= 1'b0;
			pin_prev_q <= 1'b0;
		end
		else
		begin
			pin_meta_q <= timer0_count_pin_i;
			pin_sync_q <= pin_meta_q;
			pin_prev_q <= pin_sync_q;
		end
	end

	assign pin_rise = pin_sync_q && !pin_prev_q;
	assign pin_fall = !pin_sync_q && pin_prev_q;

	assign clk_sel = clk_sel_type'(ctrl_q);

	// tick selection
	always_comb
	begin
		tick = 1'b0;
		case (clk_sel)
			clk_src_stop:     tick = 1'b0;
			clk_src_core:     tick = 1'b1;
			clk_src_div8:     tick = tap_en[0];
			clk_src_div64:    tick = tap_en[1];
			clk_src_div256:   tick = tap_en[2];
			clk_src_div1024:  tick = tap_en[3];
			clk_src_pin_fall: tick = pin_fall;
			clk_src_pin_rise: tick = pin_rise;
			default:          tick = 1'b0;
		endcase
	end

	assign wrap = tick && (count_q == 8'hff) && !(req.wr && hit_count);

	// a write wins over the tick in its own cycle, counting resumes next cycle
	assign count_d = (req.wr && hit_count) ? req.wdata[7:0] :
		(tick ? count_q + 8'h01 : count_q);

	// set beats write-one-to-clear
	assign ovf_d = wrap ? 1'b1 :
		((req.wr && hit_flag && req.wdata[`T8_OVF_BIT]) ? 1'b0 : ovf_q);

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ctrl_q   <= `T8_CTRL_RESET;
			count_q  <= `T8_COUNT_RESET;
			ovf_q    <= 1'b0;
			ovf_en_q <= 1'b0;
		end
		else
		begin
			if (req.wr && hit_ctrl)
				ctrl_q <= req.wdata[`T8_CTRL_WIDTH-1:0];
			if (req.wr && hit_mask)
				ovf_en_q <= req.wdata[`T8_OVF_BIT];
			count_q <= count_d;
			ovf_q   <= ovf_d;
		end
	end

	// read mux
	always_comb
	begin
		rdata_d = 32'h0000_0000;
		if (hit_ctrl)
			rdata_d = {29'h0, ctrl_q};
		else if (hit_count)
			rdata_d = {24'h0, count_q};
		else if (hit_flag)
			rdata_d = {31'h0, ovf_q};
		else if (hit_mask)
			rdata_d = {31'h0, ovf_en_q};
	end

	// read data registered in setup cycle so it is stable in access phase
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			rdata_q <= 32'h0000_0000;
		else if (psel_i && !penable_i && !pwrite_i)
			rdata_q <= rdata_d;
	end

	assign prdata_o = rdata_q;
	assign irq_o    = ovf_q && ovf_en_q;
endmodule : timer8_with_shared_prescaler

// >>> timer8_with_shared_prescaler_test.sv
// self-checking bench for the 8-bit timer
`timescale 1ns/1ps
module timer8_with_shared_prescaler_test;
	logic        sys_clk_i = 1'b0;
	logic        rst_n_i   = 1'b0;
	logic        psel      = 1'b0;
	logic        pen       = 1'b0;
	logic        pwr       = 1'b0;
	logic [11:0] pa        = 12'h0;
	logic [31:0] pwd       = 32'h0;
	logic [31:0] prd;
	logic [31:0] v;
	logic        rdy;
	logic        err;
	logic        es;
	logic        pin;
	logic        irq;
	int          fail_count = 0;
	int          n_tests    = 0;
	int          dv[6]      = '{1, 1, 8, 64, 256, 1024};
	initial forever #12.5 sys_clk_i = ~sys_clk_i;
	timer8_with_shared_prescaler i_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
		.psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd),
		.pstrb_i(4'hf), .prdata_o(prd), .pready_o(rdy), .pslverr_o(err),
		.timer0_count_pin_i(pin), .presc_tap_en_o(), .irq_o(irq));
	timer8_pin_src i_src (.sys_clk_i(sys_clk_i), .pin_o(pin));
	task automatic conclude;
		$display("checks %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : conclude
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", s, e, g);
		end
	endtask : chk
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge sys_clk_i);
		psel <= 1'b1;
		pwr  <= w;
		pa   <= a;
		pwd  <= d;
		@(posedge sys_clk_i);
		pen <= 1'b1;
		do
			@(posedge sys_clk_i);
		while (rdy !== 1'b1 && ++k < 20);
		if (rdy !== 1'b1)
		begin
			fail_count++;
			conclude;
		end
		v    = prd;
		es   = err;
		psel <= 1'b0;
		pen  <= 1'b0;
	endtask : xfer
	task automatic rd(input string s, input logic [11:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(s, e, v);
	endtask : rd
	task automatic t_regs;
		rd("ctrl", 12'hcc, 32'h0);
		rd("count", 12'hc8, 32'h0);
		rd("flag", 12'he0, 32'h0);
		rd("mask", 12'he4, 32'h0);
		xfer(1'b1, 12'h100, 32'h1);
		rd("unmapped", 12'h100, 32'h0);
		chk("slverr", 32'h1, es);
		xfer(1'b1, 12'hcc, 32'hff);
		rd("ctrl", 12'hcc, 32'h7);
		xfer(1'b1, 12'hcc, 32'h0);
		xfer(1'b1, 12'hc8, 32'h5a);
		repeat (20) @(posedge sys_clk_i);
		rd("count held", 12'hc8, 32'h5a);
		$display("test regs done");
	endtask : t_regs
	task automatic t_modes;
		for (int k = 0; k < 6; k++)
		begin
			xfer(1'b1, 12'hcc, k);
			xfer(1'b1, 12'hc8, 32'h0);
			repeat (4 * dv[k] - 1) @(posedge sys_clk_i);
			rd("ticks", 12'hc8, k ? 32'h4 : 32'h0);
		end
		$display("test modes done");
	endtask : t_modes
	task automatic t_ovf;
		xfer(1'b1, 12'hcc, 32'h1);
		xfer(1'b1, 12'hc8, 32'hfe);
		rd("count resumed", 12'hc8, 32'hff);
		rd("flag", 12'he0, 32'h1);
		chk("irq masked", 32'h0, irq);
		xfer(1'b1, 12'he4, 32'h1);
		@(negedge sys_clk_i);
		chk("irq", 32'h1, irq);
		xfer(1'b1, 12'he0, 32'h1);
		@(negedge sys_clk_i);
		chk("irq cleared", 32'h0, irq);
		$display("test overflow done");
	endtask : t_ovf
	task automatic t_pins;
		for (int k = 6; k < 8; k++)
		begin
			xfer(1'b1, 12'hcc, k);
			xfer(1'b1, 12'hc8, 32'h0);
			i_src.pulse(k - 3, k - 5);
			repeat (4) @(posedge sys_clk_i);
			rd("pin count", 12'hc8, k - 3);
		end
		$display("test pins done");
	endtask : t_pins
	initial
	begin
		repeat (2) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		t_regs;
		t_modes;
		t_ovf;
		t_pins;
		conclude;
	end
endmodule : timer8_with_shared_prescaler_test
bind timer8_with_shared_prescaler timer8_chk i_chk (.*);
